/* File: rtl/phy_regs_pkg.sv */
// Constants, field positions and carrier types for the PHY register bank
package phy_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_BASIC_CONTROL = 8'hE4;
    localparam logic [7:0] OFF_BASIC_STATUS  = 8'hE6;
    localparam logic [7:0] OFF_ID_LOW        = 8'hE8;
    localparam logic [7:0] OFF_ID_HIGH       = 8'hEA;
    localparam logic [7:0] OFF_PORT_CONTROL  = 8'hFA;
    localparam logic [7:0] OFF_PORT_STATUS   = 8'hFC;

    // Basic control word fields
    localparam int BC_LOOPBACK  = 14;
    localparam int BC_SPEED100  = 13;
    localparam int BC_AN_ENABLE = 12;
    localparam int BC_AN_RESTART = 9;
    localparam int BC_FULL_DUP  = 8;
    localparam int BC_XOVER_STD = 5;
    localparam int BC_FORCE_XOV = 4;
    localparam int BC_NO_AUTOX  = 3;
    localparam int BC_TX_OFF    = 1;
    localparam int BC_LED_OFF   = 0;

    // Basic status word fields
    localparam logic [15:0] BS_FIXED_ONES = 16'h7808;
    localparam int BS_AN_DONE = 5;
    localparam int BS_LINK    = 2;

    // Port control view fields
    localparam int PC_LED_OFF   = 15;
    localparam int PC_TX_OFF    = 14;
    localparam int PC_AN_RESTART = 13;
    localparam int PC_NO_AUTOX  = 10;
    localparam int PC_FORCE_XOV = 9;
    localparam int PC_AN_ENABLE = 7;
    localparam int PC_SPEED100  = 6;
    localparam int PC_FULL_DUP  = 5;

    // Port status view fields
    localparam int PS_XOVER_STD = 15;
    localparam int PS_AN_DONE   = 6;
    localparam int PS_LINK      = 5;

    // Reset values of the stored control fields
    localparam logic RST_LOOPBACK  = 1'b0;
    localparam logic RST_SPEED100  = 1'b1;
    localparam logic RST_AN_ENABLE = 1'b1;
    localparam logic RST_FULL_DUP  = 1'b1;
    localparam logic RST_XOVER_STD = 1'b1;
    localparam logic RST_OFF       = 1'b0;

    localparam int LED_COUNT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [1:0]  be;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic loopback;
        logic speed100;
        logic an_enable;
        logic an_restart;
        logic full_dup;
        logic xover_std;
        logic force_xov;
        logic no_autox;
        logic tx_off;
        logic led_off;
    } ctrl_t;

    typedef enum logic [3:0] {
        AN_IDLE = 4'b0001,
        AN_BUSY = 4'b0010,
        AN_DONE = 4'b0100,
        AN_FAIL = 4'b1000
    } an_state_t;

endpackage : phy_regs_pkg

/* File: rtl/an_tracker.sv */
// Auto-negotiation progress tracker feeding the status word
module an_tracker (
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    input  wire logic an_enable_i,
    input  wire logic restart_i,
    input  wire logic phy_an_ok_i,
    input  wire logic phy_an_fail_i,
    output logic      an_complete_o,
    output logic      an_failed_o
);
    import phy_regs_pkg::*;

    an_state_t state_q;
    an_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next state; a restart reopens negotiation whenever AN is enabled, even from done
    always_comb begin
        state_d = state_q;
        case (state_q)
            AN_IDLE: begin
                if (an_enable_i) begin
                    state_d = AN_BUSY;
                end
            end
            AN_BUSY: begin
                if (phy_an_ok_i) begin
                    state_d = AN_DONE;
                end else if (phy_an_fail_i) begin
                    state_d = AN_FAIL;
                end
            end
            AN_DONE, AN_FAIL: begin
                if (restart_i) begin
                    state_d = AN_BUSY;
                end
            end
            default: begin
                state_d = AN_IDLE;
            end
        endcase
        if (!an_enable_i) begin
            state_d = AN_IDLE;
        end else if (restart_i) begin
            state_d = AN_BUSY;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= AN_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Flags come from registered flops so the status word never glitches
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            an_complete_o <= 1'b0;
            an_failed_o   <= 1'b0;
        end else begin
            an_complete_o <= (state_d == AN_DONE);
            an_failed_o   <= (state_d == AN_FAIL);
        end
    end

endmodule : an_tracker

/* File: rtl/phy_mii_control_status_regs.sv */
// Basic control, basic status and identifier registers of the PHY port
module phy_mii_control_status_regs #(
    parameter logic [15:0] ID_LOW_VALUE  = 16'hA5C3, // Arbitrary value
    parameter logic [15:0] ID_HIGH_VALUE = 16'h3C5A  // Arbitrary value
) (
    input  wire logic                                sys_clk_i,
    input  wire logic                                nrst_i,
    input  wire phy_regs_pkg::reg_req_t              req_i,
    output logic                                     rvalid_o,
    output logic [15:0]                              rdata_o,
    input  wire logic                                link_up_i,
    input  wire logic                                phy_an_ok_i,
    input  wire logic                                phy_an_fail_i,
    input  wire logic                                an_speed100_i,
    input  wire logic                                an_full_dup_i,
    input  wire logic [phy_regs_pkg::LED_COUNT-1:0]  led_req_i,
    output logic [phy_regs_pkg::LED_COUNT-1:0]       led_o,
    output logic                                     loopback_o,
    output logic                                     speed100_o,
    output logic                                     full_dup_o,
    output logic                                     an_enable_o,
    output logic                                     an_restart_o,
    output logic                                     xover_std_o,
    output logic                                     force_crossed_o,
    output logic                                     auto_xover_off_o,
    output logic                                     tx_disable_o
);
    import phy_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word decode; the low address bit is ignored, byte lanes come from be
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:1] == off[7:1];
    endfunction : hit

    // Byte-lane merge of a write into a stored word
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wdata,
                                          input logic [1:0]  be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Storage and views

    ctrl_t       ctrl_q;
    ctrl_t       ctrl_d;
    logic        link_q;
    logic        an_complete;
    logic        an_failed;
    logic [15:0] basic_ctrl_view;
    logic [15:0] basic_stat_view;
    logic [15:0] port_ctrl_view;
    logic [15:0] port_stat_view;
    logic [15:0] bc_new;
    logic [15:0] pc_new;
    logic [15:0] rd_mux;
    logic        wr_bc;
    logic        wr_pc;

    // Basic control word as software sees it; unstored bits read zero
    always_comb begin
        basic_ctrl_view                = 16'h0000;
        basic_ctrl_view[BC_LOOPBACK]   = ctrl_q.loopback;
        basic_ctrl_view[BC_SPEED100]   = ctrl_q.speed100;
        basic_ctrl_view[BC_AN_ENABLE]  = ctrl_q.an_enable;
        basic_ctrl_view[BC_AN_RESTART] = ctrl_q.an_restart;
        basic_ctrl_view[BC_FULL_DUP]   = ctrl_q.full_dup;
        basic_ctrl_view[BC_XOVER_STD]  = ctrl_q.xover_std;
        basic_ctrl_view[BC_FORCE_XOV]  = ctrl_q.force_xov;
        basic_ctrl_view[BC_NO_AUTOX]   = ctrl_q.no_autox;
        basic_ctrl_view[BC_TX_OFF]     = ctrl_q.tx_off;
        basic_ctrl_view[BC_LED_OFF]    = ctrl_q.led_off;
    end

    // Port control view maps the same flops at other positions, except loopback and xover_std
    always_comb begin
        port_ctrl_view                = 16'h0000;
        port_ctrl_view[PC_LED_OFF]    = ctrl_q.led_off;
        port_ctrl_view[PC_TX_OFF]     = ctrl_q.tx_off;
        port_ctrl_view[PC_AN_RESTART] = ctrl_q.an_restart;
        port_ctrl_view[PC_NO_AUTOX]   = ctrl_q.no_autox;
        port_ctrl_view[PC_FORCE_XOV]  = ctrl_q.force_xov;
        port_ctrl_view[PC_AN_ENABLE]  = ctrl_q.an_enable;
        port_ctrl_view[PC_SPEED100]   = ctrl_q.speed100;
        port_ctrl_view[PC_FULL_DUP]   = ctrl_q.full_dup;
    end

    // Status words: live negotiation and link state, plus fixed abilities in basic status and xover_std in port status
    always_comb begin
        basic_stat_view             = BS_FIXED_ONES;
        basic_stat_view[BS_AN_DONE] = an_complete;
        basic_stat_view[BS_LINK]    = link_q;
        port_stat_view              = 16'h0000;
        port_stat_view[PS_XOVER_STD] = ctrl_q.xover_std;
        port_stat_view[PS_AN_DONE]  = an_complete;
        port_stat_view[PS_LINK]     = link_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path

    assign wr_bc  = req_i.wr && hit(req_i.addr, OFF_BASIC_CONTROL);
    assign wr_pc  = req_i.wr && hit(req_i.addr, OFF_PORT_CONTROL);
    assign bc_new = merge(basic_ctrl_view, req_i.wdata, req_i.be);
    assign pc_new = merge(port_ctrl_view, req_i.wdata, req_i.be);

    // Either view writes the shared flops; restart self-clears after one cycle
    always_comb begin
        ctrl_d            = ctrl_q;
        ctrl_d.an_restart = 1'b0;
        if (wr_bc) begin
            ctrl_d.loopback   = bc_new[BC_LOOPBACK];
            ctrl_d.speed100   = bc_new[BC_SPEED100];
            ctrl_d.an_enable  = bc_new[BC_AN_ENABLE];
            ctrl_d.an_restart = bc_new[BC_AN_RESTART];
            ctrl_d.full_dup   = bc_new[BC_FULL_DUP];
            ctrl_d.xover_std  = bc_new[BC_XOVER_STD];
            ctrl_d.force_xov  = bc_new[BC_FORCE_XOV];
            ctrl_d.no_autox   = bc_new[BC_NO_AUTOX];
            ctrl_d.tx_off     = bc_new[BC_TX_OFF];
            ctrl_d.led_off    = bc_new[BC_LED_OFF];
        end else if (wr_pc) begin
            ctrl_d.led_off    = pc_new[PC_LED_OFF];
            ctrl_d.tx_off     = pc_new[PC_TX_OFF];
            ctrl_d.an_restart = pc_new[PC_AN_RESTART];
            ctrl_d.no_autox   = pc_new[PC_NO_AUTOX];
            ctrl_d.force_xov  = pc_new[PC_FORCE_XOV];
            ctrl_d.an_enable  = pc_new[PC_AN_ENABLE];
            ctrl_d.speed100   = pc_new[PC_SPEED100];
            ctrl_d.full_dup   = pc_new[PC_FULL_DUP];
        end
    end

    // Control storage
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q.loopback   <= RST_LOOPBACK;
            ctrl_q.speed100   <= RST_SPEED100;
            ctrl_q.an_enable  <= RST_AN_ENABLE;
            ctrl_q.an_restart <= RST_OFF;
            ctrl_q.full_dup   <= RST_FULL_DUP;
            ctrl_q.xover_std  <= RST_XOVER_STD;
            ctrl_q.force_xov  <= RST_OFF;
            ctrl_q.no_autox   <= RST_OFF;
            ctrl_q.tx_off     <= RST_OFF;
            ctrl_q.led_off    <= RST_OFF;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Link level taken once so every view agrees in the same cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_q <= 1'b0;
        end else begin
            link_q <= link_up_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Negotiation tracking

    an_tracker u_an_tracker (
        .sys_clk_i     (sys_clk_i),
        .nrst_i        (nrst_i),
        .an_enable_i   (ctrl_q.an_enable),
        .restart_i     (ctrl_q.an_restart),
        .phy_an_ok_i   (phy_an_ok_i),
        .phy_an_fail_i (phy_an_fail_i),
        .an_complete_o (an_complete),
        .an_failed_o   (an_failed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped addresses answer zero rather than stalling

    always_comb begin
        rd_mux = 16'h0000;
        if (hit(req_i.addr, OFF_BASIC_CONTROL)) begin
            rd_mux = basic_ctrl_view;
        end else if (hit(req_i.addr, OFF_BASIC_STATUS)) begin
            rd_mux = basic_stat_view;
        end else if (hit(req_i.addr, OFF_ID_LOW)) begin
            rd_mux = ID_LOW_VALUE;
        end else if (hit(req_i.addr, OFF_ID_HIGH)) begin
            rd_mux = ID_HIGH_VALUE;
        end else if (hit(req_i.addr, OFF_PORT_CONTROL)) begin
            rd_mux = port_ctrl_view;
        end else if (hit(req_i.addr, OFF_PORT_STATUS)) begin
            rd_mux = port_stat_view;
        end
    end

    // Read data is held until the next read so slow hosts can sample it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_o <= 1'b0;
            rdata_o  <= 16'h0000;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PHY-facing controls, all from flops

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loopback_o       <= RST_LOOPBACK;
            speed100_o       <= RST_SPEED100;
            full_dup_o       <= RST_FULL_DUP;
            an_enable_o      <= RST_AN_ENABLE;
            an_restart_o     <= RST_OFF;
            xover_std_o      <= RST_XOVER_STD;
            force_crossed_o  <= RST_OFF;
            auto_xover_off_o <= RST_OFF;
            tx_disable_o     <= RST_OFF;
            led_o            <= '0;
        end else begin
            loopback_o       <= ctrl_q.loopback;
            speed100_o       <= (ctrl_q.an_enable && an_complete) ? an_speed100_i
                                                                  : ctrl_q.speed100;
            // Forced duplex also covers a negotiation that gave up
            full_dup_o       <= (ctrl_q.an_enable && !an_failed && an_complete)
                                ? an_full_dup_i : ctrl_q.full_dup;
            an_enable_o      <= ctrl_q.an_enable;
            an_restart_o     <= ctrl_q.an_restart;
            xover_std_o      <= ctrl_q.xover_std;
            force_crossed_o  <= ctrl_q.force_xov;
            auto_xover_off_o <= ctrl_q.no_autox;
            tx_disable_o     <= ctrl_q.tx_off;
            led_o            <= ctrl_q.led_off ? '0 : led_req_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_loopback;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_bc && req_i.be[1] |-> ##2 loopback_o == $past(req_i.wdata[BC_LOOPBACK], 2);
    endproperty
    a_loopback: assert property (p_loopback) else $error("Loopback output wrong");

    property p_forced_speed;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !ctrl_q.an_enable |=> speed100_o == $past(ctrl_q.speed100);
    endproperty
    a_forced_speed: assert property (p_forced_speed) else $error("Forced speed wrong");

    property p_an_enable;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_bc && req_i.be[1] && !req_i.wdata[BC_AN_ENABLE] |-> ##2 !an_enable_o;
    endproperty
    a_an_enable: assert property (p_an_enable) else $error("Negotiation not disabled");

    property p_restart;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_bc && req_i.be[1] && req_i.wdata[BC_AN_RESTART] |-> ##2 an_restart_o;
    endproperty
    a_restart: assert property (p_restart) else $error("Restart not issued");

    property p_forced_duplex;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (!ctrl_q.an_enable || an_failed) |=> full_dup_o == $past(ctrl_q.full_dup);
    endproperty
    a_forced_duplex: assert property (p_forced_duplex) else $error("Forced duplex wrong");

    property p_tx_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_bc && req_i.be[0] && req_i.wdata[BC_TX_OFF] |-> ##2 tx_disable_o;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("Transmit not disabled");

    property p_led_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ctrl_q.led_off |=> led_o == '0;
    endproperty
    a_led_off: assert property (p_led_off) else $error("LED lit while disabled");

    property p_status_fixed;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        req_i.rd && hit(req_i.addr, OFF_BASIC_STATUS)
            |=> rvalid_o && (rdata_o & 16'hF84B) == 16'h7808;
    endproperty
    a_status_fixed: assert property (p_status_fixed) else $error("Fixed status bits wrong");

    property p_link_read;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        req_i.rd && hit(req_i.addr, OFF_BASIC_STATUS) |=> rdata_o[BS_LINK] == $past(link_q);
    endproperty
    a_link_read: assert property (p_link_read) else $error("Link status wrong");

    property p_id_low;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        req_i.rd && hit(req_i.addr, OFF_ID_LOW) |=> rdata_o == ID_LOW_VALUE;
    endproperty
    a_id_low: assert property (p_id_low) else $error("Identifier low wrong");

    property p_shared_view;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_pc && req_i.be[1] |=> ctrl_q.tx_off == $past(req_i.wdata[PC_TX_OFF]);
    endproperty
    a_shared_view: assert property (p_shared_view) else $error("Shared view lost");

endmodule : phy_mii_control_status_regs

/* File: sim/phy_side_model.sv */
// Line-side PHY model: link, negotiation outcome and LED requests
module phy_side_model (
    input  wire logic [2:0] cmd_i,
    output logic            link_up_o,
    output logic            an_ok_o,
    output logic            an_fail_o,
    output logic            an_speed100_o,
    output logic            an_full_dup_o,
    output logic [1:0]      led_req_o
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////
    // Command word is {fail, ok, link}; the bench moves it just after an edge
    assign {an_fail_o, an_ok_o, link_up_o} = cmd_i;
    // Partner always settles at 10 Mbps half, so forced values stand out
    assign an_speed100_o = 1'b0;
    assign an_full_dup_o = 1'b0;
    // Activity LED follows link, the other LED is lit constantly
    assign led_req_o     = {link_up_o, 1'b1};
endmodule : phy_side_model

/* File: sim/test_phy_mii_control_status_regs.sv */
// Self-checking bench for the PHY basic control and status register bank
module test_phy_mii_control_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import phy_regs_pkg::*;

    localparam logic [15:0] ID_LO = 16'h5A01; // Arbitrary value
    localparam logic [15:0] ID_HI = 16'h0B7E; // Arbitrary value

    logic        sys_clk = 1'b0;
    logic        nrst;
    reg_req_t    req;
    logic        rvalid, link_up, an_ok, an_fail, an_spd, an_dup, an_rst;
    logic        loopback, speed100, full_dup, an_en, xover_std, force_x, autox_off, tx_dis;
    logic [15:0] rdata, w;
    logic [2:0]  phy_cmd;
    logic [1:0]  led_req, led;
    logic [15:0] exp_q[$];
    logic [7:0]  ro_addr[4];
    logic [15:0] ro_exp[4];
    int          failures, cmp_count;

    always #25 sys_clk = ~sys_clk;

    phy_mii_control_status_regs #(.ID_LOW_VALUE(ID_LO), .ID_HIGH_VALUE(ID_HI))
    phy_mii_control_status_regs_i (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .req_i(req), .rvalid_o(rvalid),
        .rdata_o(rdata), .link_up_i(link_up), .phy_an_ok_i(an_ok),
        .phy_an_fail_i(an_fail), .an_speed100_i(an_spd), .an_full_dup_i(an_dup),
        .led_req_i(led_req), .led_o(led), .loopback_o(loopback), .speed100_o(speed100),
        .full_dup_o(full_dup), .an_enable_o(an_en), .an_restart_o(an_rst),
        .xover_std_o(xover_std), .force_crossed_o(force_x),
        .auto_xover_off_o(autox_off), .tx_disable_o(tx_dis));

    phy_side_model phy_side_model_i (
        .cmd_i(phy_cmd), .link_up_o(link_up), .an_ok_o(an_ok), .an_fail_o(an_fail),
        .an_speed100_o(an_spd), .an_full_dup_o(an_dup), .led_req_o(led_req));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // One request cycle, then an idle cycle so no signal is driven twice at once
    task automatic op(input logic wen, input logic ren, input logic [7:0] a,
                      input logic [1:0] b, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wr: wen, rd: ren, be: b, wdata: d};
        @(posedge sys_clk);
        req <= '0;
    endtask : op

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, a, 2'h0, 16'h0000);
    endtask : rd

    // Control outputs against a stored control word; speed and duplex only when forced
    task automatic outs(input logic [15:0] c);
        logic [7:0] s;
        logic [7:0] e;
        #1;
        s = {loopback, an_en, xover_std, force_x, autox_off, tx_dis, led};
        e = {c[14], c[12], c[5], c[4], c[3], c[1], c[0] ? 2'h0 : {link_up, 1'b1}};
        chk(16'(s), 16'(e));
        if (!c[12]) chk(16'({speed100, full_dup}), 16'({c[13], c[8]}));
    endtask : outs

    ////////////////////////////////////////////////////////////////////////////
    // Every read answer is matched with the oldest expectation noted
    always @(posedge sys_clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
            else failures++;
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end

    initial begin
        req = '0;
        nrst = 1'b0;
        phy_cmd = 3'h0;
        failures = 0;
        cmp_count = 0;
        ro_addr = '{OFF_BASIC_STATUS, OFF_ID_LOW, OFF_ID_HIGH, 8'h20};
        ro_exp = '{16'h7808, ID_LO, ID_HI, 16'h0000};
        void'($urandom(32'hC5D9));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(OFF_BASIC_CONTROL, 16'h3120);
        outs(16'h3120);
        // Read-only and unmapped places ignore writes
        for (int k = 0; k < 2; k++) begin
            foreach (ro_addr[i]) rd(ro_addr[i], ro_exp[i]);
            if (k == 0) foreach (ro_addr[i]) op(1'b1, 1'b0, ro_addr[i], 2'h3, 16'hFFFF);
        end
        // Link up and negotiation success, then restart through the port view
        phy_cmd <= 3'b011;
        repeat (4) @(posedge sys_clk);
        rd(OFF_BASIC_STATUS, 16'h782C);
        #1 chk(16'({speed100, full_dup}), 16'h0000);
        @(posedge sys_clk) phy_cmd <= 3'b001;
        op(1'b1, 1'b0, OFF_PORT_CONTROL, 2'h3, 16'h20E0);
        // Restart reaches the PHY as a one-cycle pulse two edges after the write
        @(posedge sys_clk);
        #1 chk(16'(an_rst), 16'h0001);
        @(posedge sys_clk);
        #1 chk(16'(an_rst), 16'h0000);
        @(posedge sys_clk);
        rd(OFF_BASIC_STATUS, 16'h780C);
        rd(OFF_BASIC_CONTROL, 16'h3120);
        // Failed negotiation falls back to the forced duplex
        @(posedge sys_clk) phy_cmd <= 3'b101;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'({speed100, full_dup}), 16'h0003);
        @(posedge sys_clk) phy_cmd <= 3'b001;
        // Low byte only: bit 9 lives in the high byte and must stay clear
        op(1'b1, 1'b0, OFF_BASIC_CONTROL, 2'h1, 16'hFFFF);
        rd(OFF_BASIC_CONTROL, 16'h313B);
        outs(16'h313B);
        for (int i = 0; i < 8; i++) begin
            // First pass also restarts negotiation; the restart bit reads back clear
            w = 16'($urandom()) & 16'h733B;
            if (i == 0) w[9] = 1'b1;
            op(1'b1, 1'b0, OFF_BASIC_CONTROL, 2'h3, w);
            w = w & 16'hFDFF;
            rd(OFF_BASIC_CONTROL, w);
            outs(w);
        end
        // Port control view shares the flops; clearing AN enable drops completion
        op(1'b1, 1'b0, OFF_PORT_CONTROL, 2'h3, 16'h8000);
        rd(OFF_BASIC_CONTROL, (w & 16'h4020) | 16'h0001);
        rd(OFF_PORT_STATUS, {w[5], 15'h0020});
        rd(OFF_PORT_CONTROL, 16'h8000);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk);
        if (exp_q.size() != 0) failures++;
        wrap_up();
    end
endmodule : test_phy_mii_control_status_regs
